// file: hw/cvp_protect.sv
/*
  Cell voltage limit protection: lockout detection, end-of-charge,
  pre-charge steering and the overvoltage delay timer, with the
  threshold registers on a byte-wide register port.
  Assumes scan results, requests and compare levels come from logic on
  the same clock, one scan_valid_i pulse per measurement of all cells.
*/
`timescale 1ns/1ps

module cvp_protect #(
  parameter int NUM_CELLS = 8,
  parameter int VOLT_W    = 12
) (
  // Clock and reset
  input  wire logic                          clock_i,
  input  wire logic                          rst_i,
  // Register port
  input  wire logic [7:0]                    reg_addr_i,
  input  wire logic                          reg_write_i,
  input  wire logic [7:0]                    reg_wdata_i,
  output logic      [7:0]                    reg_rdata_o,
  // Measurement scan
  input  wire logic                          scan_valid_i,
  input  wire logic [NUM_CELLS*VOLT_W-1:0]   cell_voltage_i,
  input  wire logic [VOLT_W-1:0]             overvoltage_recovery_threshold_i,
  input  wire logic [VOLT_W-1:0]             undervoltage_recovery_threshold_i,
  input  wire logic                          ov_compare_i,
  // Control bits and requests
  input  wire logic                          precharge_enable_i,
  input  wire logic                          powerdown_on_lockout_i,
  input  wire logic                          charge_request_i,
  input  wire logic                          discharge_request_i,
  input  wire logic [NUM_CELLS-1:0]          balance_request_i,
  // FET and pin outputs
  output logic                               charge_fet_out_o,
  output logic                               precharge_fet_out_o,
  output logic                               discharge_fet_out_o,
  output logic [NUM_CELLS-1:0]               cell_balance_o,
  output logic                               pack_shutdown_out_o,
  output logic                               end_of_charge_n_o,
  output logic                               powerdown_o,
  // Status
  output logic                               overvoltage_lockout_flag_o,
  output logic                               undervoltage_lockout_flag_o,
  output logic                               end_of_charge_flag_o,
  output logic                               low_voltage_charge_flag_o,
  output logic                               ov_condition_o
);

  logic [7:0]        cfg_reg [cvp_pkg::CFG_COUNT];
  logic [11:0]       overvoltage_lockout_threshold_thr;
  logic [11:0]       undervoltage_lockout_threshold_thr;
  logic [11:0]       eoc_thr;
  logic [11:0]       prech_thr;
  logic [9:0]        delay_count;
  cvp_pkg::cvp_unit_type delay_unit;

  logic              any_over_overvoltage_lockout_threshold;
  logic              all_below_ovr;
  logic              any_under_undervoltage_lockout_threshold;
  logic              all_above_uvr;
  logic              any_over_eoc;
  logic              any_under_prech;
  logic [2:0]        overvoltage_lockout_threshold_cnt_reg;
  logic [2:0]        undervoltage_lockout_threshold_cnt_reg;
  logic              overvoltage_lockout_threshold_next;
  logic              undervoltage_lockout_threshold_next;
  logic              eoc_next;
  logic              lvc_next;

  logic [3:0]        us_cnt_reg;
  logic [9:0]        ms_cnt_reg;
  logic [9:0]        s_cnt_reg;
  logic [5:0]        min_cnt_reg;
  logic [9:0]        unit_cnt_reg;
  logic              tick_us;
  logic              tick_ms;
  logic              tick_s;
  logic              tick_min;
  logic              unit_tick;

  function automatic logic [11:0] join12(input logic [7:0] lo, input logic [7:0] hi);
    return {hi[3:0], lo};
  endfunction : join12

  function automatic logic [2:0] scan_step(input logic [2:0] cnt, input logic hit);
    if (!hit)
      return 3'h0;
    else if (cnt == 3'(cvp_pkg::LOCKOUT_SCANS))
      return cnt;
    else
      return cnt + 3'h1;
  endfunction : scan_step

  // Threshold fields
  assign overvoltage_lockout_threshold_thr    = join12(cfg_reg[0], cfg_reg[1]);
  assign undervoltage_lockout_threshold_thr    = join12(cfg_reg[2], cfg_reg[3]);
  assign eoc_thr     = join12(cfg_reg[4], cfg_reg[5]);
  assign prech_thr   = join12(cfg_reg[6], cfg_reg[7]);
  assign delay_count = {cfg_reg[9][1:0], cfg_reg[8]};
  assign delay_unit  = cvp_pkg::cvp_unit_type'(cfg_reg[9][3:2]);

  // Register writes; reserved nibbles are not stored
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < cvp_pkg::CFG_COUNT; i++) begin
        cfg_reg[i] <= cvp_pkg::CFG_RESET[i];
      end
    end else if (reg_write_i && reg_addr_i >= cvp_pkg::OVERVOLTAGE_LOCKOUT_THRESHOLD_LO_ADDR
                 && reg_addr_i <= cvp_pkg::OVERVOLTAGE_DELAY_COUNT_HI_ADDR) begin
      if (reg_addr_i[0])
        cfg_reg[4'(reg_addr_i - cvp_pkg::OVERVOLTAGE_LOCKOUT_THRESHOLD_LO_ADDR)] <= {4'h0, reg_wdata_i[3:0]};
      else
        cfg_reg[4'(reg_addr_i - cvp_pkg::OVERVOLTAGE_LOCKOUT_THRESHOLD_LO_ADDR)] <= reg_wdata_i;
    end
  end

  // Read data follows the address one cycle later
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_o <= 8'h00;
    end else begin
      if (reg_addr_i >= cvp_pkg::OVERVOLTAGE_LOCKOUT_THRESHOLD_LO_ADDR && reg_addr_i <= cvp_pkg::OVERVOLTAGE_DELAY_COUNT_HI_ADDR)
        reg_rdata_o <= cfg_reg[4'(reg_addr_i - cvp_pkg::OVERVOLTAGE_LOCKOUT_THRESHOLD_LO_ADDR)];
      else if (reg_addr_i == cvp_pkg::FAULT_ADDR)
        reg_rdata_o <= 8'((32'(overvoltage_lockout_flag_o) << cvp_pkg::OVERVOLTAGE_LOCKOUT_THRESHOLD_FLAG_BIT)
                          | (32'(undervoltage_lockout_flag_o) << cvp_pkg::UNDERVOLTAGE_LOCKOUT_THRESHOLD_FLAG_BIT));
      else if (reg_addr_i == cvp_pkg::STATUS1_ADDR)
        reg_rdata_o <= 8'(32'(end_of_charge_flag_o) << cvp_pkg::EOC_FLAG_BIT);
      else if (reg_addr_i == cvp_pkg::STATUS2_ADDR)
        reg_rdata_o <= 8'(32'(low_voltage_charge_flag_o) << cvp_pkg::LVC_FLAG_BIT);
      else
        reg_rdata_o <= 8'h00;
    end
  end

  // Per-scan comparisons across all cells
  always_comb begin
    any_over_overvoltage_lockout_threshold   = 1'b0;
    all_below_ovr   = 1'b1;
    any_under_undervoltage_lockout_threshold  = 1'b0;
    all_above_uvr   = 1'b1;
    any_over_eoc    = 1'b0;
    any_under_prech = 1'b0;
    for (int c = 0; c < NUM_CELLS; c++) begin
      if (cell_voltage_i[c*VOLT_W +: VOLT_W] > overvoltage_lockout_threshold_thr)
        any_over_overvoltage_lockout_threshold = 1'b1;
      if (cell_voltage_i[c*VOLT_W +: VOLT_W] >= overvoltage_recovery_threshold_i)
        all_below_ovr = 1'b0;
      if (cell_voltage_i[c*VOLT_W +: VOLT_W] < undervoltage_lockout_threshold_thr)
        any_under_undervoltage_lockout_threshold = 1'b1;
      if (cell_voltage_i[c*VOLT_W +: VOLT_W] <= undervoltage_recovery_threshold_i)
        all_above_uvr = 1'b0;
      if (cell_voltage_i[c*VOLT_W +: VOLT_W] > eoc_thr)
        any_over_eoc = 1'b1;
      if (cell_voltage_i[c*VOLT_W +: VOLT_W] < prech_thr)
        any_under_prech = 1'b1;
    end
    // A disabled threshold never counts as a hit
    if (overvoltage_lockout_threshold_thr == cvp_pkg::OVERVOLTAGE_LOCKOUT_THRESHOLD_DISABLE)
      any_over_overvoltage_lockout_threshold = 1'b0;
    if (undervoltage_lockout_threshold_thr == cvp_pkg::UNDERVOLTAGE_LOCKOUT_THRESHOLD_DISABLE)
      any_under_undervoltage_lockout_threshold = 1'b0;
  end

  // Consecutive scan counters
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      overvoltage_lockout_threshold_cnt_reg <= 3'h0;
      undervoltage_lockout_threshold_cnt_reg <= 3'h0;
    end else if (scan_valid_i) begin
      overvoltage_lockout_threshold_cnt_reg <= scan_step(overvoltage_lockout_threshold_cnt_reg, any_over_overvoltage_lockout_threshold);
      undervoltage_lockout_threshold_cnt_reg <= scan_step(undervoltage_lockout_threshold_cnt_reg, any_under_undervoltage_lockout_threshold);
    end
  end

  // Lockout and level flags, next values shared by the FET logic
  always_comb begin
    overvoltage_lockout_threshold_next = overvoltage_lockout_flag_o && overvoltage_lockout_threshold_thr != cvp_pkg::OVERVOLTAGE_LOCKOUT_THRESHOLD_DISABLE;
    undervoltage_lockout_threshold_next = undervoltage_lockout_flag_o && undervoltage_lockout_threshold_thr != cvp_pkg::UNDERVOLTAGE_LOCKOUT_THRESHOLD_DISABLE;
    eoc_next  = end_of_charge_flag_o;
    lvc_next  = low_voltage_charge_flag_o;
    if (scan_valid_i) begin
      // Entry wins over recovery within one scan
      if (any_over_overvoltage_lockout_threshold && overvoltage_lockout_threshold_cnt_reg == 3'(cvp_pkg::LOCKOUT_SCANS - 1))
        overvoltage_lockout_threshold_next = 1'b1;
      else if (all_below_ovr || overvoltage_lockout_threshold_thr == cvp_pkg::OVERVOLTAGE_LOCKOUT_THRESHOLD_DISABLE)
        overvoltage_lockout_threshold_next = 1'b0;
      if (any_under_undervoltage_lockout_threshold && undervoltage_lockout_threshold_cnt_reg == 3'(cvp_pkg::LOCKOUT_SCANS - 1))
        undervoltage_lockout_threshold_next = 1'b1;
      else if (all_above_uvr || undervoltage_lockout_threshold_thr == cvp_pkg::UNDERVOLTAGE_LOCKOUT_THRESHOLD_DISABLE)
        undervoltage_lockout_threshold_next = 1'b0;
      eoc_next = any_over_eoc;
      lvc_next = any_under_prech;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      overvoltage_lockout_flag_o  <= 1'b0;
      undervoltage_lockout_flag_o <= 1'b0;
      end_of_charge_flag_o        <= 1'b0;
      low_voltage_charge_flag_o   <= 1'b0;
      end_of_charge_n_o           <= 1'b1;
      pack_shutdown_out_o         <= 1'b0;
      powerdown_o                 <= 1'b0;
    end else begin
      overvoltage_lockout_flag_o  <= overvoltage_lockout_threshold_next;
      undervoltage_lockout_flag_o <= undervoltage_lockout_threshold_next;
      end_of_charge_flag_o        <= eoc_next;
      end_of_charge_n_o           <= !eoc_next;
      low_voltage_charge_flag_o   <= lvc_next;
      pack_shutdown_out_o         <= overvoltage_lockout_threshold_next;
      // Not gated by host FET control: only powerdown_on_lockout_i gates the lockout
      powerdown_o                 <= undervoltage_lockout_threshold_next && powerdown_on_lockout_i;
    end
  end

  // FET drive, from next flags so outputs and flags move together
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      charge_fet_out_o    <= 1'b0;
      precharge_fet_out_o <= 1'b0;
      discharge_fet_out_o <= 1'b0;
      cell_balance_o      <= '0;
    end else begin
      charge_fet_out_o    <= charge_request_i && !overvoltage_lockout_threshold_next
                             && !(precharge_enable_i && lvc_next);
      precharge_fet_out_o <= charge_request_i && !overvoltage_lockout_threshold_next
                             && precharge_enable_i && lvc_next;
      discharge_fet_out_o <= discharge_request_i && !undervoltage_lockout_threshold_next;
      cell_balance_o      <= (overvoltage_lockout_threshold_next || undervoltage_lockout_threshold_next) ? '0 : balance_request_i;
    end
  end

  // Delay timer prescalers restart with the compare, so no unit starts partial
  assign tick_us  = us_cnt_reg == 4'(cvp_pkg::CYCLES_PER_US - 1);
  assign tick_ms  = tick_us && ms_cnt_reg == 10'(cvp_pkg::US_PER_MS - 1);
  assign tick_s   = tick_ms && s_cnt_reg == 10'(cvp_pkg::MS_PER_S - 1);
  assign tick_min = tick_s && min_cnt_reg == 6'(cvp_pkg::S_PER_MIN - 1);

  always_comb begin
    unique case (delay_unit)
      cvp_pkg::UNIT_US:  unit_tick = tick_us;
      cvp_pkg::UNIT_MS:  unit_tick = tick_ms;
      cvp_pkg::UNIT_S:   unit_tick = tick_s;
      cvp_pkg::UNIT_MIN: unit_tick = tick_min;
    endcase
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      us_cnt_reg  <= 4'h0;
      ms_cnt_reg  <= 10'h000;
      s_cnt_reg   <= 10'h000;
      min_cnt_reg <= 6'h00;
    end else if (!ov_compare_i) begin
      us_cnt_reg  <= 4'h0;
      ms_cnt_reg  <= 10'h000;
      s_cnt_reg   <= 10'h000;
      min_cnt_reg <= 6'h00;
    end else begin
      us_cnt_reg <= tick_us ? 4'h0 : us_cnt_reg + 4'h1;
      if (tick_us)
        ms_cnt_reg <= tick_ms ? 10'h000 : ms_cnt_reg + 10'h001;
      if (tick_ms)
        s_cnt_reg <= tick_s ? 10'h000 : s_cnt_reg + 10'h001;
      if (tick_s)
        min_cnt_reg <= tick_min ? 6'h00 : min_cnt_reg + 6'h01;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      unit_cnt_reg   <= 10'h000;
      ov_condition_o <= 1'b0;
    end else begin
      if (!ov_compare_i)
        unit_cnt_reg <= 10'h000;
      else if (unit_tick && unit_cnt_reg != 10'h3FF)
        unit_cnt_reg <= unit_cnt_reg + 10'h001;
      ov_condition_o <= ov_compare_i && unit_cnt_reg >= delay_count;
    end
  end

  // Checks
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  sequence s_overvoltage_lockout_threshold_trip;
    scan_valid_i && any_over_overvoltage_lockout_threshold && overvoltage_lockout_threshold_cnt_reg == 3'h4;
  endsequence
  sequence s_undervoltage_lockout_threshold_trip;
    scan_valid_i && any_under_undervoltage_lockout_threshold && undervoltage_lockout_threshold_cnt_reg == 3'h4;
  endsequence

  a_overvoltage_lockout_threshold_entry: assert property (s_overvoltage_lockout_threshold_trip |=> overvoltage_lockout_flag_o
    && pack_shutdown_out_o && cell_balance_o == '0)
    else $error("overvoltage lockout not entered on fifth scan");

  a_overvoltage_lockout_threshold_too_early: assert property ($rose(overvoltage_lockout_flag_o)
    |-> $past(overvoltage_lockout_threshold_cnt_reg) == 3'h4)
    else $error("overvoltage lockout entered before fifth scan");

  a_charge_blocked: assert property (overvoltage_lockout_flag_o
    |-> !charge_fet_out_o && !precharge_fet_out_o)
    else $error("charge FET driven during overvoltage lockout");

  a_overvoltage_lockout_threshold_disabled: assert property (overvoltage_lockout_threshold_thr == 12'hFFF
    |=> !overvoltage_lockout_flag_o)
    else $error("overvoltage lockout active while disabled");

  a_undervoltage_lockout_threshold_entry: assert property (s_undervoltage_lockout_threshold_trip |=> undervoltage_lockout_flag_o
    && !discharge_fet_out_o ##0 powerdown_o == powerdown_on_lockout_i)
    else $error("undervoltage lockout entry effects wrong");

  a_undervoltage_lockout_threshold_disabled: assert property (undervoltage_lockout_threshold_thr == 12'h000
    |=> !undervoltage_lockout_flag_o)
    else $error("undervoltage lockout active while disabled");

  a_overvoltage_lockout_threshold_recover: assert property (overvoltage_lockout_flag_o && scan_valid_i
    && all_below_ovr && !any_over_overvoltage_lockout_threshold |=> !overvoltage_lockout_flag_o)
    else $error("overvoltage lockout did not recover");

  a_count_restart: assert property (scan_valid_i && !any_over_overvoltage_lockout_threshold
    |=> overvoltage_lockout_threshold_cnt_reg == 3'h0)
    else $error("lockout scan counter not restarted");

  a_eoc_pin: assert property (end_of_charge_n_o == !end_of_charge_flag_o)
    else $error("end-of-charge pin disagrees with flag");

  a_precharge_sel: assert property (scan_valid_i && any_under_prech
    && precharge_enable_i && charge_request_i && !overvoltage_lockout_threshold_next
    |=> precharge_fet_out_o && !charge_fet_out_o)
    else $error("pre-charge FET not selected");

  a_ov_delay: assert property (!ov_compare_i ##1 ov_compare_i [*3]
    ##0 delay_count > 10'h000 |-> !ov_condition_o)
    else $error("overvoltage declared before delay");

  a_ov_drop: assert property (!ov_compare_i |=> !ov_condition_o)
    else $error("overvoltage held after compare dropped");

endmodule : cvp_protect

// file: inc/cvp_pkg.sv
/*
  Constants for the cell voltage limit protection block: register
  offsets, reset values, status bit positions and timing counts.
  Assumes a 10 MHz system clock and 12-bit cell measurement codes.
*/
package cvp_pkg;

  // Clock and timing
  localparam int CLK_PERIOD_NS    = 100;
  localparam int US_NS            = 1000;
  localparam int CYCLES_PER_US    = (US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int US_PER_MS        = 1000;
  localparam int MS_PER_S         = 1000;
  localparam int S_PER_MIN        = 60;
  localparam int LOCKOUT_SCANS    = 5;

  // Register offsets
  localparam logic [7:0] OVERVOLTAGE_LOCKOUT_THRESHOLD_LO_ADDR   = 8'h08;
  localparam logic [7:0] OVERVOLTAGE_LOCKOUT_THRESHOLD_HI_ADDR   = 8'h09;
  localparam logic [7:0] UNDERVOLTAGE_LOCKOUT_THRESHOLD_LO_ADDR   = 8'h0A;
  localparam logic [7:0] UNDERVOLTAGE_LOCKOUT_THRESHOLD_HI_ADDR   = 8'h0B;
  localparam logic [7:0] EOC_LO_ADDR    = 8'h0C;
  localparam logic [7:0] EOC_HI_ADDR    = 8'h0D;
  localparam logic [7:0] PRECH_LO_ADDR  = 8'h0E;
  localparam logic [7:0] PRECH_HI_ADDR  = 8'h0F;
  localparam logic [7:0] OVERVOLTAGE_DELAY_COUNT_LO_ADDR   = 8'h10;
  localparam logic [7:0] OVERVOLTAGE_DELAY_COUNT_HI_ADDR   = 8'h11;
  localparam logic [7:0] FAULT_ADDR     = 8'h80;
  localparam logic [7:0] STATUS1_ADDR   = 8'h81;
  localparam logic [7:0] STATUS2_ADDR   = 8'h82;
  localparam int         CFG_COUNT      = 10;

  // Status bit positions
  localparam int OVERVOLTAGE_LOCKOUT_THRESHOLD_FLAG_BIT = 1;
  localparam int UNDERVOLTAGE_LOCKOUT_THRESHOLD_FLAG_BIT = 3;
  localparam int EOC_FLAG_BIT  = 7;
  localparam int LVC_FLAG_BIT  = 7;

  // Threshold values that switch a lockout off
  localparam logic [11:0] OVERVOLTAGE_LOCKOUT_THRESHOLD_DISABLE = 12'hFFF;
  localparam logic [11:0] UNDERVOLTAGE_LOCKOUT_THRESHOLD_DISABLE = 12'h000;

  // Reset values, index 0 is offset 0x08
  localparam logic [7:0] CFG_RESET [CFG_COUNT] = '{
    8'h7F, 8'h0E, 8'h00, 8'h06, 8'hFF, 8'h0D, 8'hAA, 8'h07, 8'h01, 8'h08
  };

  // Delay unit selector
  typedef enum logic [1:0] {
    UNIT_US  = 2'b00,
    UNIT_MS  = 2'b01,
    UNIT_S   = 2'b10,
    UNIT_MIN = 2'b11
  } cvp_unit_type;

endpackage : cvp_pkg

// file: testbench/cvp_front_end.sv
/*
  Behavioural cell measurement front end: on request it delivers one
  scan pulse carrying cell 0 at one code and every other cell at another.
  Assumes requests come from the bench on the falling clock edge.
*/
`timescale 1ns/1ps

module cvp_front_end #(
  parameter int NUM_CELLS = 8
) (
  // Clock and reset
  input  wire logic                   clock_i,
  input  wire logic                   rst_i,
  // Scan request
  input  wire logic                   fire_i,
  input  wire logic [11:0]            cell_first_i,
  input  wire logic [11:0]            cell_rest_i,
  // Scan result
  output logic                        scan_valid_o,
  output logic [NUM_CELLS*12-1:0]     cell_voltage_o
);
  logic pend_reg;

  initial begin
    scan_valid_o   = 1'b0;
    cell_voltage_o = '0;
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      pend_reg <= 1'b0;
    end else begin
      pend_reg <= fire_i;
    end
  end

  // Codes only valid with the pulse; scrambled otherwise so nothing stale matches
  always @(negedge clock_i) begin
    if (pend_reg) begin
      scan_valid_o   <= 1'b1;
      cell_voltage_o <= {{(NUM_CELLS-1){cell_rest_i}}, cell_first_i};
    end else begin
      scan_valid_o   <= 1'b0;
      cell_voltage_o <= ~cell_voltage_o;
    end
  end
endmodule : cvp_front_end

// file: testbench/testbench.sv
/*
  Self-checking bench for the cell voltage limit protection block.
  Assumes the front end model supplies scans; registers, requests and
  compare inputs are driven here on the falling clock edge.
*/
`timescale 1ns/1ps

module testbench;
  logic         clock_i = 1'b0;
  logic         rst_i = 1'b1;
  logic [7:0]   reg_addr_i = 8'h00;
  logic         reg_write_i = 1'b0;
  logic [7:0]   reg_wdata_i = 8'h00;
  logic [7:0]   reg_rdata_o;
  logic         scan_valid;
  logic [95:0]  cell_voltage;
  logic         ov_compare_i = 1'b0;
  logic         precharge_enable_i = 1'b0;
  logic         powerdown_on_lockout_i = 1'b1;
  logic         charge_request_i = 1'b1;
  logic         discharge_request_i = 1'b1;
  logic [7:0]   cell_balance_o;
  logic         fire = 1'b0;
  logic [11:0]  cell_first = 12'h000;
  logic [11:0]  cell_rest = 12'h000;
  logic         chg, pre, dis, shut, eoc_n, pd, ovf, uvf, eocf, lvf, ovc;
  int           n_errors = 0;
  int           cmp_count = 0;
  wire  [9:0]   outs = {chg, pre, dis, shut, eoc_n, pd, ovf, uvf, eocf, lvf};

  always #50 clock_i = ~clock_i;

  cvp_front_end u_fe (.clock_i(clock_i), .rst_i(rst_i), .fire_i(fire),
    .cell_first_i(cell_first), .cell_rest_i(cell_rest),
    .scan_valid_o(scan_valid), .cell_voltage_o(cell_voltage));

  cvp_protect u_dut (.clock_i(clock_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
    .reg_write_i(reg_write_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .scan_valid_i(scan_valid), .cell_voltage_i(cell_voltage),
    .overvoltage_recovery_threshold_i(12'h600),
    .undervoltage_recovery_threshold_i(12'h300), .ov_compare_i(ov_compare_i),
    .precharge_enable_i(precharge_enable_i),
    .powerdown_on_lockout_i(powerdown_on_lockout_i),
    .charge_request_i(charge_request_i), .discharge_request_i(discharge_request_i),
    .balance_request_i(8'hFF), .charge_fet_out_o(chg), .precharge_fet_out_o(pre),
    .discharge_fet_out_o(dis), .cell_balance_o(cell_balance_o),
    .pack_shutdown_out_o(shut), .end_of_charge_n_o(eoc_n), .powerdown_o(pd),
    .overvoltage_lockout_flag_o(ovf), .undervoltage_lockout_flag_o(uvf),
    .end_of_charge_flag_o(eocf), .low_voltage_charge_flag_o(lvf),
    .ov_condition_o(ovc));

  task automatic end_sim;
    $display("checks %0d errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_sim

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic wt(input int n);
    repeat (n) @(negedge clock_i);
  endtask : wt

  // Strobe drops for a full cycle so writes never merge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr_i  = a;
    reg_wdata_i = d;
    reg_write_i = 1'b1;
    wt(1);
    reg_write_i = 1'b0;
    wt(1);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    reg_addr_i = a;
    wt(1);
    chk("rdata", reg_rdata_o, exp);
  endtask : rd

  task automatic thr(input logic [7:0] a, input logic [11:0] v);
    wr(a, v[7:0]);
    wr(a + 8'h01, {4'h0, v[11:8]});
  endtask : thr

  task automatic scan(input int n, input logic [11:0] a, input logic [11:0] b);
    repeat (n) begin
      cell_first = a;
      cell_rest  = b;
      fire       = 1'b1;
      wt(1);
      fire       = 1'b0;
      wt(1);
    end
  endtask : scan

  task automatic tmr(input logic [7:0] lo, input logic [7:0] hi, input int n0, input int n1);
    wr(8'h10, lo);
    wr(8'h11, hi);
    ov_compare_i = 1'b1;
    wt(n0);
    chk("ov_cond early", ovc, 16'h0000);
    wt(n1 - n0);
    chk("ov_cond late", ovc, 16'h0001);
    ov_compare_i = 1'b0;
    wt(2);
    chk("ov_cond drop", ovc, 16'h0000);
  endtask : tmr

  initial begin
    repeat (50000) @(posedge clock_i);
    n_errors++;
    $display("FAIL watchdog expected done seen timeout");
    end_sim();
  end

  initial begin
    wt(5);
    rst_i = 1'b0;
    chk("outs reset", outs, 16'h0020);
    for (int i = 0; i < cvp_pkg::CFG_COUNT; i++) begin
      rd(8'h08 + 8'(i), cvp_pkg::CFG_RESET[i]);
    end
    wr(8'h12, 8'h55);
    rd(8'h12, 8'h00);
    wr(8'h09, 8'hFF);
    rd(8'h09, 8'h0F);
    // Lockout above ordinary overvoltage range
    thr(8'h08, 12'h800);
    thr(8'h0A, 12'h100);
    thr(8'h0C, 12'h700);
    thr(8'h0E, 12'h200);
    rd(8'h0D, 8'h07);
    scan(1, 12'h500, 12'h500);
    chk("outs idle", outs, 16'h02A0);
    scan(4, 12'h900, 12'h500);
    chk("outs ov4", outs, 16'h0282);
    scan(1, 12'h500, 12'h500);
    scan(4, 12'h900, 12'h500);
    chk("outs restart", outs, 16'h0282);
    scan(1, 12'h900, 12'h500);
    chk("outs overvoltage_lockout_threshold", outs, 16'h00CA);
    chk("balance overvoltage_lockout_threshold", cell_balance_o, 16'h0000);
    rd(8'h80, 8'h02);
    precharge_enable_i = 1'b1;
    scan(1, 12'h180, 12'h700);
    chk("outs hold", outs, 16'h00E9);
    precharge_enable_i = 1'b0;
    scan(1, 12'h500, 12'h500);
    chk("outs ov rec", outs, 16'h02A0);
    chk("balance rec", cell_balance_o, 16'h00FF);
    scan(5, 12'h900, 12'h500);
    chk("outs ov again", outs, 16'h00CA);
    thr(8'h08, 12'hFFF);
    chk("outs ov clear", outs, 16'h0282);
    scan(5, 12'hFFF, 12'h500);
    chk("outs ov off", outs, 16'h0282);
    thr(8'h08, 12'h800);
    charge_request_i = 1'b0;
    scan(4, 12'h080, 12'h500);
    chk("outs uv4", outs, 16'h00A1);
    scan(1, 12'h080, 12'h500);
    chk("outs undervoltage_lockout_threshold", outs, 16'h0035);
    chk("balance undervoltage_lockout_threshold", cell_balance_o, 16'h0000);
    rd(8'h80, 8'h08);
    scan(1, 12'h400, 12'h400);
    chk("outs uv rec", outs, 16'h00A0);
    powerdown_on_lockout_i = 1'b0;
    scan(5, 12'h080, 12'h400);
    chk("outs undervoltage_lockout_threshold no pd", outs, 16'h0025);
    thr(8'h0A, 12'h000);
    chk("outs uv clear", outs, 16'h00A1);
    scan(5, 12'h000, 12'h400);
    chk("outs uv off", outs, 16'h00A1);
    charge_request_i   = 1'b1;
    precharge_enable_i = 1'b1;
    scan(1, 12'h180, 12'h400);
    chk("outs prech", outs, 16'h01A1);
    scan(1, 12'h400, 12'h400);
    chk("outs charge", outs, 16'h02A0);
    precharge_enable_i = 1'b0;
    scan(1, 12'h180, 12'h400);
    chk("outs no prech", outs, 16'h02A1);
    thr(8'h0E, 12'h000);
    scan(1, 12'h100, 12'h400);
    chk("outs lv off", outs, 16'h02A0);
    scan(1, 12'h701, 12'h400);
    chk("outs eoc", outs, 16'h0282);
    scan(1, 12'h700, 12'h400);
    chk("outs eoc edge", outs, 16'h02A0);
    tmr(8'h02, 8'h00, 20, 25);
    tmr(8'h00, 8'h00, 0, 3);
    tmr(8'h00, 8'h01, 2560, 2570);
    tmr(8'h01, 8'h04, 10000, 10010);
    // Seconds and minutes are too long to finish; show they outlast a millisecond
    for (int u = 2; u < 4; u++) begin
      wr(8'h10, 8'h01);
      wr(8'h11, 8'(u << 2));
      ov_compare_i = 1'b1;
      wt(10010);
      chk("ov_cond slow unit", ovc, 16'h0000);
      ov_compare_i = 1'b0;
      wt(2);
    end
    end_sim();
  end
endmodule : testbench
